/* verilog/jbt_defs.svh */
`ifndef JBT_DEFS_SVH
`define JBT_DEFS_SVH
// Contract
// - Instruction register is ten bits wide
// - Code 0x005 samples pins, preloads scan cells
// - Code 0x00F drives cells out, captures inputs
// - Code 0x3FF: one-bit bypass, pins normal
// - Code 0x007: 32-bit user code, default ones
// - Code 0x006 shifts identification value out
// - Code 0x00B: bypass, all pins high impedance
// - Code 0x00A: bypass, pins held from cells
// - Codes 0x00C, 0x00E route through user chains
// - Pull-ups and bus-hold stay as configured
// - Boundary register length is a device parameter
// - Identification: version, part, maker, flag fields
// - Configuration instructions share the same port
// - Identification least significant bit reads one
// - User chain exposes TAP signals and state

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define JBT_IR_LEN 10
`define JBT_OP_SAMPLE 10'h005
`define JBT_OP_EXTEST 10'h00F
`define JBT_OP_BYPASS 10'h3FF
`define JBT_OP_USERCODE 10'h007
`define JBT_OP_IDCODE 10'h006
`define JBT_OP_HIGHZ 10'h00B
`define JBT_OP_CLAMP 10'h00A
`define JBT_OP_USER_A 10'h00C
`define JBT_OP_USER_B 10'h00E
// Capture pattern of the instruction register, low two bits 01
`define JBT_IR_CAPTURE 10'h001

// ----------------------------------------------------------------
// Data register sizes and reset values
// ----------------------------------------------------------------
`define JBT_BSR_LEN 240
`define JBT_UCODE_LEN 32
`define JBT_UCODE_RESET 32'hFFFFFFFF
`define JBT_ID_LEN 32
// Identification fields; values arbitrary except the flag, fixed at one
`define JBT_ID_VERSION 4'h1
`define JBT_ID_PART 16'h5A5A
`define JBT_ID_MAKER 11'h123
`define JBT_ID_FLAG 1'h1
`endif

/* verilog/jbt_pkg.sv */
package jbt_pkg;
  // Standard TAP controller states
  typedef enum logic [3:0] {
    JBT_RESET, JBT_IDLE, JBT_SEL_DR, JBT_CAP_DR, JBT_SH_DR, JBT_EX1_DR,
    JBT_PAU_DR, JBT_EX2_DR, JBT_UPD_DR, JBT_SEL_IR, JBT_CAP_IR,
    JBT_SH_IR, JBT_EX1_IR, JBT_PAU_IR, JBT_EX2_IR, JBT_UPD_IR
  } jbt_state_t;
endpackage

/* verilog/jbt_shreg.sv */
`timescale 1ns/1ps
// Capture/shift register with LSB toward the serial output
module jbt_shreg #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controls, gated to TCK rising edges
  input wire logic cap,
  input wire logic sh,
  input wire logic [W-1:0] par_in,
  input wire logic ser_in,
  // Contents
  output logic [W-1:0] q
);
  logic [W-1:0] next_q;

  // Capture wins over shift; both only on a qualified edge
  always_comb begin
    next_q = q;
    if (cap) begin
      next_q = par_in;
    end else if (sh) begin
      next_q = {ser_in, q[W-1:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

/* verilog/jbt_tap.sv */
`timescale 1ns/1ps
`include "jbt_defs.svh"
module jbt_tap import jbt_pkg::*; (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Test port pins, asynchronous to clk
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Core side of the device pins
  input wire logic [`JBT_BSR_LEN-1:0] core_out,
  input wire logic [`JBT_BSR_LEN-1:0] pin_in,
  output logic [`JBT_BSR_LEN-1:0] pin_out,
  output logic pin_tristate,
  output logic pin_keep_weak,
  // Programmed user code value
  input wire logic [`JBT_UCODE_LEN-1:0] user_code,
  input wire logic user_code_set,
  // User chain access
  output logic user_chain_a_instr,
  output logic user_chain_b_instr,
  output logic user_tdi,
  output logic user_tck_rise,
  output logic [3:0] user_state,
  input wire logic user_tdo_a,
  input wire logic user_tdo_b,
  // Current instruction, for the configuration engine
  output logic [`JBT_IR_LEN-1:0] instr
);
  // ----------------------------------------------------------------
  // Pin synchronisers and TCK edge detection
  // ----------------------------------------------------------------
  logic [2:0] tck_s;
  logic [1:0] tms_s;
  logic [1:0] tdi_s;
  logic rise;
  logic fall;
  logic ms;
  logic di;

  // Third tck stage feeds edge detector only from the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
    end
  end

  assign rise = tck_s[1] & ~tck_s[2];
  assign fall = ~tck_s[1] & tck_s[2];
  assign ms = tms_s[1];
  assign di = tdi_s[1];

  // ----------------------------------------------------------------
  // TAP state machine
  // ----------------------------------------------------------------
  jbt_state_t state;
  jbt_state_t next_state;

  // Standard sixteen-state walk, stepped on TCK rise
  always_comb begin
    next_state = state;
    if (rise) begin
      unique case (state)
        JBT_RESET: next_state = ms ? JBT_RESET : JBT_IDLE;
        JBT_IDLE: next_state = ms ? JBT_SEL_DR : JBT_IDLE;
        JBT_SEL_DR: next_state = ms ? JBT_SEL_IR : JBT_CAP_DR;
        JBT_CAP_DR: next_state = ms ? JBT_EX1_DR : JBT_SH_DR;
        JBT_SH_DR: next_state = ms ? JBT_EX1_DR : JBT_SH_DR;
        JBT_EX1_DR: next_state = ms ? JBT_UPD_DR : JBT_PAU_DR;
        JBT_PAU_DR: next_state = ms ? JBT_EX2_DR : JBT_PAU_DR;
        JBT_EX2_DR: next_state = ms ? JBT_UPD_DR : JBT_SH_DR;
        JBT_UPD_DR: next_state = ms ? JBT_SEL_DR : JBT_IDLE;
        JBT_SEL_IR: next_state = ms ? JBT_RESET : JBT_CAP_IR;
        JBT_CAP_IR: next_state = ms ? JBT_EX1_IR : JBT_SH_IR;
        JBT_SH_IR: next_state = ms ? JBT_EX1_IR : JBT_SH_IR;
        JBT_EX1_IR: next_state = ms ? JBT_UPD_IR : JBT_PAU_IR;
        JBT_PAU_IR: next_state = ms ? JBT_EX2_IR : JBT_PAU_IR;
        JBT_EX2_IR: next_state = ms ? JBT_UPD_IR : JBT_SH_IR;
        JBT_UPD_IR: next_state = ms ? JBT_SEL_DR : JBT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= JBT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [`JBT_IR_LEN-1:0] ir_sh;
  logic [`JBT_IR_LEN-1:0] next_ir_sh;
  logic [`JBT_IR_LEN-1:0] next_instr;

  // Ten-bit shift path; takes effect only in update
  always_comb begin
    next_ir_sh = ir_sh;
    next_instr = instr;
    if (rise) begin
      unique case (state)
        JBT_CAP_IR: next_ir_sh = `JBT_IR_CAPTURE;
        JBT_SH_IR: next_ir_sh = {di, ir_sh[`JBT_IR_LEN-1:1]};
        default: next_ir_sh = ir_sh;
      endcase
    end
    // Update acts on the falling edge, as the standard requires
    if (fall && state == JBT_UPD_IR) begin
      next_instr = ir_sh;
    end
    // Test-logic reset falls back to identification
    if (state == JBT_RESET) begin
      next_instr = `JBT_OP_IDCODE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_sh <= `JBT_IR_CAPTURE;
      instr <= `JBT_OP_IDCODE;
    end else begin
      ir_sh <= next_ir_sh;
      instr <= next_instr;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic sel_bsr;
  logic sel_ucode;
  logic sel_id;
  logic is_extest;
  logic is_highz;
  logic is_clamp;

  assign sel_bsr = (instr == `JBT_OP_SAMPLE) | is_extest;
  assign is_extest = instr == `JBT_OP_EXTEST;
  assign sel_ucode = instr == `JBT_OP_USERCODE;
  assign sel_id = instr == `JBT_OP_IDCODE;
  assign is_highz = instr == `JBT_OP_HIGHZ;
  assign is_clamp = instr == `JBT_OP_CLAMP;
  assign user_chain_a_instr = instr == `JBT_OP_USER_A;
  assign user_chain_b_instr = instr == `JBT_OP_USER_B;
  // Bypass, high-Z, clamp and any other code use the one-bit path

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  logic cap_dr;
  logic sh_dr;
  logic [`JBT_BSR_LEN-1:0] bsr_q;
  logic [`JBT_BSR_LEN-1:0] bsr_upd;
  logic [`JBT_BSR_LEN-1:0] next_bsr_upd;
  logic [`JBT_UCODE_LEN-1:0] ucode_q;
  logic [`JBT_UCODE_LEN-1:0] ucode_val;
  logic [`JBT_ID_LEN-1:0] id_q;
  logic [`JBT_ID_LEN-1:0] id_val;
  logic byp;
  logic next_byp;

  assign cap_dr = rise && state == JBT_CAP_DR;
  assign sh_dr = rise && state == JBT_SH_DR;

  // Length of the cell chain is a device-size constant
  jbt_shreg #(.W(`JBT_BSR_LEN)) u_bsr (
    .clk(clk),
    .rst_b(rst_b),
    .cap(cap_dr & sel_bsr),
    .sh(sh_dr & sel_bsr),
    .par_in(pin_in),
    .ser_in(di),
    .q(bsr_q)
  );

  // Unprogrammed user code reads all ones
  assign ucode_val = user_code_set ? user_code : `JBT_UCODE_RESET;

  jbt_shreg #(.W(`JBT_UCODE_LEN)) u_ucode (
    .clk(clk),
    .rst_b(rst_b),
    .cap(cap_dr & sel_ucode),
    .sh(sh_dr & sel_ucode),
    .par_in(ucode_val),
    .ser_in(di),
    .q(ucode_q)
  );

  // Version, part, maker, then a fixed one
  assign id_val = {`JBT_ID_VERSION, `JBT_ID_PART, `JBT_ID_MAKER,
                   `JBT_ID_FLAG};

  jbt_shreg #(.W(`JBT_ID_LEN)) u_id (
    .clk(clk),
    .rst_b(rst_b),
    .cap(cap_dr & sel_id),
    .sh(sh_dr & sel_id),
    .par_in(id_val),
    .ser_in(di),
    .q(id_q)
  );

  // Bypass bit captures zero; preload latch updates on falling TCK
  always_comb begin
    next_byp = byp;
    next_bsr_upd = bsr_upd;
    if (cap_dr) begin
      next_byp = 1'b0;
    end else if (sh_dr) begin
      next_byp = di;
    end
    if (fall && state == JBT_UPD_DR && sel_bsr) begin
      next_bsr_upd = bsr_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byp <= 1'b0;
      bsr_upd <= '0;
    end else begin
      byp <= next_byp;
      bsr_upd <= next_bsr_upd;
    end
  end

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------
  // Extest and clamp drive held cells; others pass core
  assign pin_out = (is_extest | is_clamp) ? bsr_upd : core_out;
  assign pin_tristate = is_highz;
  // Weak pull-ups and bus-hold never overridden by test modes
  assign pin_keep_weak = 1'b1;

  // ----------------------------------------------------------------
  // User chain exposure
  // ----------------------------------------------------------------
  // TAP data and state shown whenever a user chain is active
  assign user_tdi = (user_chain_a_instr | user_chain_b_instr) & di;
  assign user_tck_rise = (user_chain_a_instr | user_chain_b_instr) & rise;
  assign user_state = (user_chain_a_instr | user_chain_b_instr)
                      ? state : 4'h0;

  // ----------------------------------------------------------------
  // Serial output, changed on falling TCK
  // ----------------------------------------------------------------
  logic next_tdo;
  logic next_tdo_oe;

  always_comb begin
    next_tdo = tdo;
    next_tdo_oe = tdo_oe;
    if (fall) begin
      next_tdo_oe = (state == JBT_SH_DR) || (state == JBT_SH_IR);
      if (state == JBT_SH_IR) begin
        next_tdo = ir_sh[0];
      end else if (sel_bsr) begin
        next_tdo = bsr_q[0];
      end else if (sel_ucode) begin
        next_tdo = ucode_q[0];
      end else if (sel_id) begin
        next_tdo = id_q[0];
      end else if (user_chain_a_instr) begin
        next_tdo = user_tdo_a;
      end else if (user_chain_b_instr) begin
        next_tdo = user_tdo_b;
      end else begin
        next_tdo = byp;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end
endmodule

/* sim/jbt_checker.sv */
`timescale 1ns/1ps
`include "jbt_defs.svh"
module jbt_checker import jbt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Test port
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  // Pins
  input wire logic [`JBT_BSR_LEN-1:0] core_out,
  input wire logic [`JBT_BSR_LEN-1:0] pin_out,
  input wire logic pin_tristate,
  input wire logic pin_keep_weak,
  // User chain and instruction
  input wire logic user_chain_a_instr,
  input wire logic user_chain_b_instr,
  input wire logic user_tck_rise,
  input wire logic user_tdi,
  input wire logic [3:0] user_state,
  input wire logic [`JBT_IR_LEN-1:0] instr
);
  // One domain, so one clocking and one reset for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Decodes follow the held instruction
  highz_dec_a: assert property (
    pin_tristate == (instr == `JBT_OP_HIGHZ)) else $error("tristate");
  user_dec_a: assert property (
    user_chain_a_instr == (instr == `JBT_OP_USER_A)) else $error("chain a");
  keep_weak_a: assert property (pin_keep_weak) else $error("weak");
  pins_normal_a: assert property (
    !(instr == `JBT_OP_EXTEST || instr == `JBT_OP_CLAMP) |->
    pin_out == core_out) else $error("pins");
  // User side sees nothing unless a chain is chosen
  user_hidden_a: assert property (
    !(user_chain_a_instr || user_chain_b_instr) |->
    user_state == 4'h0 && !user_tck_rise) else $error("user leak");
  user_tdi_a: assert property (
    !(user_chain_a_instr || user_chain_b_instr) |-> !user_tdi)
    else $error("user tdi leak");
  tck_rise_a: assert property (
    user_chain_a_instr && $rose(tck) |-> ##[1:4] user_tck_rise)
    else $error("no tck pulse");
  // Output and instruction move only on the low phase of the link;
  // test-logic reset may load identification while the link is high
  tdo_fall_a: assert property (
    $changed(tdo) |-> !$past(tck, 2)) else $error("tdo edge");
  instr_upd_a: assert property (
    $changed(instr) |-> !tdo_oe &&
    (!$past(tck, 2) || instr == `JBT_OP_IDCODE)) else $error("instr");
endmodule
bind jbt_tap jbt_checker chk (.clk(clk), .rst_b(rst_b), .tck(tck),
  .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out),
  .pin_tristate(pin_tristate), .pin_keep_weak(pin_keep_weak),
  .user_chain_a_instr(user_chain_a_instr),
  .user_chain_b_instr(user_chain_b_instr),
  .user_tck_rise(user_tck_rise), .user_tdi(user_tdi),
  .user_state(user_state), .instr(instr));

/* sim/jbt_host_model.sv */
`timescale 1ns/1ps
module jbt_host_model (
  // Link to the device
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // Link clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 200 ns period; tdo taken just before the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #100;
    o = tdo;
    tck = 1'b1;
    #100;
    tck = 1'b0;
  endtask
  // Five ones reach test-logic reset from anywhere, then idle
  task automatic reset_tap();
    logic o;
    repeat (5) tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
  endtask
  // Idle, capture, n bits LSB first, update, idle
  task automatic scan(input logic ir, input int n,
    input logic [255:0] din, output logic [255:0] dout);
    logic o;
    dout = '0;
    #3; // Keeps link edges off the clk edges
    tick(1'b1, tdi, o);
    if (ir) tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
    tick(1'b0, tdi, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
    tdi = ~tdi; // Released line must not keep its last value
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "jbt_defs.svh"
module tb_top import jbt_pkg::*;;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  localparam logic [31:0] ID_EXP = {`JBT_ID_VERSION, `JBT_ID_PART,
    `JBT_ID_MAKER, 1'b1};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, pin_tristate, pin_keep_weak, user_tdi;
  logic [`JBT_BSR_LEN-1:0] core_out, pin_in, pin_out, cells;
  logic [31:0] user_code;
  logic user_code_set, chain_a, chain_b, user_tck_rise, tdo_a, tdo_b;
  logic [3:0] user_state;
  logic [9:0] instr;
  logic [255:0] din, dout;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'hce9e;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  jbt_tap DUT (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_tristate(pin_tristate),
    .pin_keep_weak(pin_keep_weak), .user_code(user_code),
    .user_code_set(user_code_set), .user_chain_a_instr(chain_a),
    .user_chain_b_instr(chain_b), .user_tdi(user_tdi),
    .user_tck_rise(user_tck_rise), .user_state(user_state),
    .user_tdo_a(tdo_a), .user_tdo_b(tdo_b), .instr(instr));
  jbt_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function automatic logic [255:0] rnd();
    logic [255:0] r;
    for (int i = 0; i < 8; i++) r[i*32 +: 32] = $random(seed);
    return r;
  endfunction
  // Model: selected register bits, bypass delays tdi by one
  function automatic logic [255:0] ref_dr(input logic [9:0] ir,
    input int n, input logic [255:0] d);
    logic [255:0] c;
    logic [255:0] r;
    logic byp;
    byp = 1'b0;
    r = '0;
    case (ir)
      `JBT_OP_IDCODE: c = 256'(ID_EXP);
      `JBT_OP_USERCODE: c = 256'(user_code_set ? user_code :
        `JBT_UCODE_RESET);
      `JBT_OP_SAMPLE, `JBT_OP_EXTEST: c = 256'(pin_in);
      `JBT_OP_USER_A: c = {256{tdo_a}};
      `JBT_OP_USER_B: c = {256{tdo_b}};
      default: c = '0;
    endcase
    if (ir == `JBT_OP_BYPASS || ir == `JBT_OP_HIGHZ || ir == `JBT_OP_CLAMP)
      byp = 1'b1;
    for (int i = 0; i < n; i++) r[i] = byp ? (i == 0 ? 1'b0 : d[i-1]) : c[i];
    return r;
  endfunction
  // Load an instruction, then scan n random bits through its register
  task automatic op(input logic [9:0] code, input int n);
    host.scan(1'b1, 10, 256'(code), dout);
    `CHK("ir_capture", `JBT_IR_CAPTURE, dout[9:0])
    `CHK("instr", code, instr)
    din = rnd();
    host.scan(1'b0, n, din, dout);
    `CHK("dr_out", ref_dr(code, n, din), dout)
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog, well beyond the ~0.18 ms the sequence needs
  initial begin
    #2000000;
    bad_count++;
    end_sim();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    core_out = 240'(rnd());
    pin_in = 240'(rnd());
    user_code = 32'($random(seed));
    user_code_set = 1'b0;
    tdo_a = 1'b1;
    tdo_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    host.reset_tap();
    `CHK("instr_reset", `JBT_OP_IDCODE, instr)
    din = rnd();
    host.scan(1'b0, 32, din, dout);
    `CHK("id_reset", 256'(ID_EXP), dout)
    op(`JBT_OP_USERCODE, 32);
    @(negedge clk) user_code_set = 1'b1;
    op(`JBT_OP_USERCODE, 32);
    op(`JBT_OP_BYPASS, 16);
    `CHK("bypass_pins", core_out, pin_out)
    op(`JBT_OP_SAMPLE, 240);
    `CHK("sample_pins", core_out, pin_out)
    @(negedge clk) pin_in = 240'(rnd());
    op(`JBT_OP_EXTEST, 240);
    cells = din[`JBT_BSR_LEN-1:0];
    `CHK("extest_pins", cells, pin_out)
    op(`JBT_OP_CLAMP, 8);
    `CHK("clamp_pins", cells, pin_out)
    op(`JBT_OP_HIGHZ, 8);
    `CHK("highz", 1'b1, pin_tristate)
    `CHK("keep_weak", 1'b1, pin_keep_weak)
    // Five ones from a non-default instruction must restore identification
    host.reset_tap();
    `CHK("tlr_instr", `JBT_OP_IDCODE, instr)
    `CHK("tlr_highz", 1'b0, pin_tristate)
    op(`JBT_OP_USER_A, 12);
    `CHK("user_state", 4'(JBT_IDLE), user_state)
    repeat (3) @(negedge clk);
    `CHK("user_tdi", tdi, user_tdi)
    op(`JBT_OP_USER_B, 12);
    `CHK("chain_b", 1'b1, chain_b)
    // Mid-run reset drops the chain and falls back to identification
    @(negedge clk) rst_b = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("rst_instr", `JBT_OP_IDCODE, instr)
    `CHK("rst_chain", 1'b0, chain_b)
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    host.reset_tap();
    op(`JBT_OP_IDCODE, 32);
    end_sim();
  end
endmodule
